/* File: hdl/icd_top.sv */
/*
  Top of the copy engine, channel one: APB slave, register file and
  transfer engine; every output registered.
  Assumes memory controllers answer MEM_REQ with MEM_GNT in some cycle.
*/
`timescale 1ns/1ns
module icd_top (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic        CE,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        MEM_GNT,
	input  wire logic [31:0] MEM_RDATA,
	output logic             MEM_REQ,
	output logic             MEM_WE,
	output logic      [31:0] MEM_ADDR,
	output logic      [31:0] MEM_WDATA,
	output logic      [2:0]  ARBITRATION_RANK,
	output logic             CHANNEL_ONE_DONE_IRQ
);
	icd_job_if   jb ();
	logic [31:0] prdata_next;
	logic        pslverr_next;
	logic        req_n;
	logic        we_n;
	logic [31:0] addr_n;
	logic [31:0] wdata_n;
	logic        done_n;
	logic [2:0]  rank_n;

	icd_regs u_regs (
		.clk          (CLK),
		.nrst         (NRST),
		.ce           (CE),
		.psel         (PSEL),
		.penable      (PENABLE),
		.pwrite       (PWRITE),
		.paddr        (PADDR),
		.pwdata       (PWDATA),
		.prdata_next  (prdata_next),
		.pslverr_next (pslverr_next),
		.jb           (jb.regs)
	);

	icd_engine u_eng (
		.clk            (CLK),
		.nrst           (NRST),
		.ce             (CE),
		.mem_gnt        (MEM_GNT && MEM_REQ),
		.mem_rdata      (MEM_RDATA),
		.mem_req_next   (req_n),
		.mem_we_next    (we_n),
		.mem_addr_next  (addr_n),
		.mem_wdata_next (wdata_n),
		.done_pulse     (done_n),
		.rank           (rank_n),
		.jb             (jb.eng)
	);

	// ==========================================================
	// APB answer: PREADY pulses in the cycle after setup, so no wait state
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else if (CE) begin
			PREADY  <= PSEL && !PENABLE;
			PRDATA  <= prdata_next;
			PSLVERR <= pslverr_next && PSEL && !PENABLE;
		end
	end

	// ==========================================================
	// Registered memory port and interrupt; grant is qualified by MEM_REQ
	// because the registered request lags the engine state by one cycle
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			MEM_REQ              <= 1'b0;
			MEM_WE               <= 1'b0;
			MEM_ADDR             <= 32'h00000000;
			MEM_WDATA            <= 32'h00000000;
			ARBITRATION_RANK     <= 3'h0;
			CHANNEL_ONE_DONE_IRQ <= 1'b0;
		end else if (CE) begin
			MEM_REQ              <= req_n && !(MEM_GNT && MEM_REQ);
			MEM_WE               <= we_n;
			MEM_ADDR             <= addr_n;
			MEM_WDATA            <= wdata_n;
			ARBITRATION_RANK     <= rank_n;
			CHANNEL_ONE_DONE_IRQ <= done_n;
		end
	end
endmodule

/* File: hdl/icd_defines.svh */
/*
  Constants of the internal copy engine, channel one: register offsets,
  field positions, reset values and codes.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
// How it works
// - Copy reads use the source register with its two low bits forced to zero.
// - Fill writes the full 32-bit source value to every destination word.
// - Count bits 31..29 give arbitration rank, 0 most urgent, 7 least.
// - Count bit 28 set raises the done interrupt at completion.
// - Count bits 27..17 read as zero and ignore writes.
// - Count bit 16 chooses copy (0) or fill (1).
// - Zero length moves nothing, completes at once, interrupts if enabled.
// - A transfer queued behind a zero-length one starts without delay.
// - Status is read only; source, destination and count are read-write.
// - Running flag sets when a job starts its first read (copy) or write (fill), clears after last write.
// - Queued flag sets on a submit while running, clears with the running flag, one cycle before the queued job starts.
`ifndef ICD_DEFINES_SVH
`define ICD_DEFINES_SVH

// ==========================================================
// Register offsets
`define ICD_OFS_STATE   12'h000
`define ICD_OFS_SOURCE  12'h004
`define ICD_OFS_DEST    12'h008
`define ICD_OFS_COUNT   12'h00c

// ==========================================================
// Count register fields
`define ICD_RANK_HI     31
`define ICD_RANK_LO     29
`define ICD_IRQ_EN_BIT  28
`define ICD_FILL_BIT    16
`define ICD_LEN_HI      15
`define ICD_COUNT_MASK  32'hf001ffff

// ==========================================================
// Status bits and reset values
`define ICD_STAT_RUN    0
`define ICD_STAT_QUEUE  1
`define ICD_RST_WORD    32'h00000000

`endif

/* File: hdl/icd_pkg.sv */
/*
  Types of the internal copy engine, channel one.
  Assumes icd_defines.svh for the numbers.
*/
package icd_pkg;

	// ==========================================================
	// Engine states, one-hot
	typedef enum logic [3:0] {
		ICD_IDLE  = 4'b0001,
		ICD_READ  = 4'b0010,
		ICD_WRITE = 4'b0100,
		ICD_DONE  = 4'b1000
	} icd_state_e;

	// ==========================================================
	// One submitted transfer
	typedef struct packed {
		logic [31:0] source;
		logic [31:0] dest;
		logic [2:0]  rank;
		logic        irq_en;
		logic        fill;
		logic [15:0] length;
	} icd_job_s;

endpackage

/* File: hdl/icd_job_if.sv */
/*
  Interface carrying one submitted transfer from the register file to
  the engine, with the engine's acceptance strobe.
  Assumes a single clock domain.
*/
`timescale 1ns/1ns
interface icd_job_if;
	icd_pkg::icd_job_s job;
	logic              job_valid;
	logic              job_take;
	logic              running;

	modport regs (output job, output job_valid, input job_take, input running);
	modport eng  (input job, input job_valid, output job_take, output running);
endinterface

/* File: hdl/icd_regs.sv */
/*
  APB register file of the copy engine: source, destination, count and
  status; holds one queued transfer.
  Assumes APB master timing and icd_defines.svh.
*/
`timescale 1ns/1ns
`include "icd_defines.svh"
module icd_regs (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata_next,
	output logic             pslverr_next,
	icd_job_if.regs          jb
);
	logic [31:0] source_reg;
	logic [31:0] dest_reg;
	logic [31:0] count_reg;
	logic        queued_reg;
	logic        wr;
	logic [31:0] count_w;

	assign wr      = psel && penable && pwrite;
	assign count_w = pwdata & `ICD_COUNT_MASK;

	// ==========================================================
	// Programmable registers, all read-write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			source_reg <= `ICD_RST_WORD;
			dest_reg   <= `ICD_RST_WORD;
			count_reg  <= `ICD_RST_WORD;
		end else if (ce && wr) begin
			if (paddr == `ICD_OFS_SOURCE) source_reg <= pwdata;
			if (paddr == `ICD_OFS_DEST)   dest_reg   <= pwdata;
			if (paddr == `ICD_OFS_COUNT)  count_reg  <= count_w;
		end
	end

	// ==========================================================
	// Submit on count write; a new submit beats the take of the old one
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			queued_reg <= 1'b0;
		end else if (ce) begin
			if (wr && paddr == `ICD_OFS_COUNT)
				queued_reg <= 1'b1;
			else if (jb.job_take)
				queued_reg <= 1'b0;
		end
	end

	assign jb.job_valid = queued_reg;
	assign jb.job = '{source: source_reg, dest: dest_reg,
		rank: count_reg[`ICD_RANK_HI:`ICD_RANK_LO], irq_en: count_reg[`ICD_IRQ_EN_BIT],
		fill: count_reg[`ICD_FILL_BIT], length: count_reg[`ICD_LEN_HI:0]};

	// ==========================================================
	// Read mux; status shows queued only behind a running transfer
	always_comb begin
		prdata_next  = `ICD_RST_WORD;
		pslverr_next = 1'b0;
		unique case (paddr)
			`ICD_OFS_STATE: begin
				prdata_next[`ICD_STAT_RUN]   = jb.running;
				prdata_next[`ICD_STAT_QUEUE] = queued_reg && jb.running;
				pslverr_next = pwrite;
			end
			`ICD_OFS_SOURCE: prdata_next = source_reg;
			`ICD_OFS_DEST:   prdata_next = dest_reg;
			`ICD_OFS_COUNT:  prdata_next = count_reg;
			default:         pslverr_next = 1'b1;
		endcase
	end
endmodule

/* File: hdl/icd_engine.sv */
/*
  Transfer engine: takes a submitted job, reads or fills word by word and
  writes the destination over a simple request/grant memory port.
  Assumes memory read data arrives in the cycle the read is granted.
*/
`timescale 1ns/1ns
`include "icd_defines.svh"
module icd_engine (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        mem_gnt,
	input  wire logic [31:0] mem_rdata,
	output logic             mem_req_next,
	output logic             mem_we_next,
	output logic      [31:0] mem_addr_next,
	output logic      [31:0] mem_wdata_next,
	output logic             done_pulse,
	output logic      [2:0]  rank,
	icd_job_if.eng           jb
);
	icd_pkg::icd_state_e state_reg;
	icd_pkg::icd_job_s   cur_reg;
	logic [31:0]         src_reg;
	logic [31:0]         dst_reg;
	logic [13:0]         words_reg;
	logic [31:0]         data_reg;
	logic                start;

	// Idle or just finished: a queued job starts at once, even after zero length
	assign start        = jb.job_valid && (state_reg == icd_pkg::ICD_IDLE
		|| state_reg == icd_pkg::ICD_DONE);
	assign jb.job_take  = ce && start;
	assign jb.running   = (state_reg == icd_pkg::ICD_READ) || (state_reg == icd_pkg::ICD_WRITE);
	assign rank         = cur_reg.rank;

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= icd_pkg::ICD_IDLE;
			cur_reg   <= '0;
			src_reg   <= `ICD_RST_WORD;
			dst_reg   <= `ICD_RST_WORD;
			words_reg <= 14'h0000;
			data_reg  <= `ICD_RST_WORD;
		end else if (ce) begin
			unique case (state_reg)
				icd_pkg::ICD_IDLE, icd_pkg::ICD_DONE: begin
					if (start) begin
						cur_reg   <= jb.job;
						src_reg   <= {jb.job.source[31:2], 2'b00};
						dst_reg   <= {jb.job.dest[31:2], 2'b00};
						words_reg <= jb.job.length[15:2];
						data_reg  <= jb.job.source;
						if (jb.job.length[15:2] == 14'h0000)
							state_reg <= icd_pkg::ICD_DONE;
						else if (jb.job.fill)
							state_reg <= icd_pkg::ICD_WRITE;
						else
							state_reg <= icd_pkg::ICD_READ;
					end else begin
						state_reg <= icd_pkg::ICD_IDLE;
					end
				end
				icd_pkg::ICD_READ: begin
					if (mem_gnt) begin
						data_reg  <= mem_rdata;
						src_reg   <= src_reg + 32'h00000004;
						state_reg <= icd_pkg::ICD_WRITE;
					end
				end
				icd_pkg::ICD_WRITE: begin
					if (mem_gnt) begin
						dst_reg   <= dst_reg + 32'h00000004;
						words_reg <= words_reg - 14'h0001;
						if (words_reg == 14'h0001)
							state_reg <= icd_pkg::ICD_DONE;
						else if (!cur_reg.fill)
							state_reg <= icd_pkg::ICD_READ;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Memory request decode and completion
	always_comb begin
		mem_req_next   = jb.running;
		mem_we_next    = state_reg == icd_pkg::ICD_WRITE;
		mem_addr_next  = mem_we_next ? dst_reg : src_reg;
		mem_wdata_next = data_reg;
		done_pulse     = ce && state_reg == icd_pkg::ICD_DONE && cur_reg.irq_en;
	end
endmodule

/* File: dv/icd_assertions.sv */
/*
  Port checker of the copy engine top: APB handshake, memory port, done pulse.
  Assumes it is bound to icd_top and sees only its ports.
*/
`timescale 1ns/1ns
module icd_assertions (
	input wire logic        CLK,
	input wire logic        NRST,
	input wire logic        CE,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        MEM_GNT,
	input wire logic [31:0] MEM_RDATA,
	input wire logic        MEM_REQ,
	input wire logic        MEM_WE,
	input wire logic [31:0] MEM_ADDR,
	input wire logic [31:0] MEM_WDATA,
	input wire logic [2:0]  ARBITRATION_RANK,
	input wire logic        CHANNEL_ONE_DONE_IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// ==========================================================
	// Bus steps; CE stays high in the bench, so no freeze is allowed for
	sequence apb_setup;
		PSEL && !PENABLE;
	endsequence
	sequence apb_read_done(logic [11:0] a);
		PSEL && PENABLE && !PWRITE && PADDR == a && PREADY;
	endsequence
	AST_READY_AFTER_SETUP: assert property (apb_setup |=> PREADY)
		else $error("no ready after setup");
	AST_READY_ONE_CYCLE: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	AST_STATUS_WRITE_REFUSED: assert property (
		apb_setup ##0 (PWRITE && PADDR == 12'h000) |=> PSLVERR)
		else $error("status write accepted");
	AST_COUNT_RESERVED_ZERO: assert property (
		apb_read_done(12'h00c) |-> PRDATA[27:17] == 11'h000)
		else $error("count reserved bits set");
	AST_STATUS_RESERVED_ZERO: assert property (
		apb_read_done(12'h000) |-> PRDATA[31:2] == 30'h0)
		else $error("status reserved bits set");
	// ==========================================================
	// Memory port and done pulse
	AST_READ_ALIGNED: assert property (MEM_REQ && !MEM_WE |-> MEM_ADDR[1:0] == 2'b00)
		else $error("copy read not word aligned");
	AST_REQ_HELD: assert property (
		MEM_REQ && !MEM_GNT |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE)
		&& $stable(MEM_WDATA))
		else $error("memory request dropped or changed");
	AST_IRQ_PULSE: assert property (CHANNEL_ONE_DONE_IRQ |=> !CHANNEL_ONE_DONE_IRQ)
		else $error("done pulse longer than one cycle");
	// A held request belongs to one job, so its rank cannot move under it
	AST_RANK_HELD: assert property (
		MEM_REQ && $past(MEM_REQ) |-> $stable(ARBITRATION_RANK))
		else $error("rank changed during a transfer");
endmodule

bind icd_top icd_assertions icd_assertions_inst (.CLK(CLK), .NRST(NRST), .CE(CE), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_GNT(MEM_GNT), .MEM_RDATA(MEM_RDATA),
	.MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
	.ARBITRATION_RANK(ARBITRATION_RANK), .CHANNEL_ONE_DONE_IRQ(CHANNEL_ONE_DONE_IRQ));

/* File: dv/icd_mem_model.sv */
/*
  Local memory seen by the copy engine: grants requests, prompt or slow.
  Assumes grant and read data belong to the same edge.
*/
`timescale 1ns/1ns
module icd_mem_model (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic        SLOW,
	input  wire logic        MEM_REQ,
	input  wire logic        MEM_WE,
	input  wire logic [31:0] MEM_ADDR,
	output logic             MEM_GNT,
	output logic      [31:0] MEM_RDATA
);
	logic [2:0] wait_reg;
	// Local memory answers every word address; grant only with a request
	assign MEM_GNT = MEM_REQ && wait_reg == 3'h0;
	// Data is valid only in the grant cycle; inverted otherwise so stale reads show
	assign MEM_RDATA = (MEM_GNT && !MEM_WE) ? {MEM_ADDR[15:0], ~MEM_ADDR[31:16]} :
		~{MEM_ADDR[15:0], ~MEM_ADDR[31:16]};
	// A slow memory stalls up to seven cycles after each grant
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wait_reg <= 3'h0;
		end else if (MEM_GNT) begin
			wait_reg <= SLOW ? 3'($urandom_range(7)) : 3'h0;
		end else if (wait_reg != 3'h0) begin
			wait_reg <= wait_reg - 3'h1;
		end
	end
endmodule

/* File: dv/tb.sv */
/*
  Self-checking bench of the copy engine top with a local memory model.
  Assumes APB with one-cycle ready and CE held high after reset.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        slow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, rd, s;
	logic        pready, pslverr, mem_gnt, mem_req, mem_we, irq, err;
	logic [2:0]  rank, exp_rank;
	int          fails = 0, samples_checked = 0, cyc = 0, irq_seen = 0, irq_exp = 0;
	logic [63:0] exp_q[$];
	always #5 clk = ~clk;
	icd_top icd_top_inst (.CLK(clk), .NRST(nrst), .CE(ce), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .MEM_GNT(mem_gnt), .MEM_RDATA(mem_rdata), .MEM_REQ(mem_req),
		.MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
		.ARBITRATION_RANK(rank), .CHANNEL_ONE_DONE_IRQ(irq));
	icd_mem_model icd_mem_model_inst (.CLK(clk), .NRST(nrst), .SLOW(slow), .MEM_REQ(mem_req),
		.MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_GNT(mem_gnt), .MEM_RDATA(mem_rdata));
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[31:16]};
	endfunction
	// ==========================================================
	// Monitor: every granted write must match the next expected word
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
		if (irq === 1'b1) irq_seen++;
		if (mem_req && mem_gnt && mem_we) begin
			if (exp_q.size() == 0) `CHK("spurious write", 1'b0, 1'b1)
			else begin
				`CHK("write addr", exp_q[0][63:32], mem_addr)
				`CHK("write data", exp_q[0][31:0], mem_wdata)
				void'(exp_q.pop_front());
			end
		end
	end
	// One APB transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait as long as the slave needs; only the bench timeout ends a hang
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Source and destination first; the count write submits
	task automatic submit(input logic [31:0] src, dst, c);
		int k;
		for (k = 0; k < int'(c[15:2]); k++)
			exp_q.push_back({dst + 32'(4 * k),
				c[16] ? src : pat({src[31:2], 2'b00} + 32'(4 * k))});
		if (c[28]) irq_exp++;
		exp_rank = c[31:29];
		apb(1'b1, 12'h004, src);
		apb(1'b1, 12'h008, dst);
		apb(1'b1, 12'h00c, c);
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 3000; i++) begin
			@(posedge clk);
			if (exp_q.size() == 0) break;
		end
		repeat (10) @(posedge clk);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("status idle", 32'h0, rd)
		`CHK("done pulses", irq_exp, irq_seen)
		`CHK("rank", exp_rank, rank)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		logic [31:0] v;
		int t;
		void'($urandom(32'h0bffd148));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		ce <= 1'b1;
		// Zero-length copy submits with random rank and interrupt bits
		for (t = 0; t < 4; t++) begin
			v = $urandom() & 32'hfffe0000;
			s = $urandom();
			submit(s, $urandom() & 32'hfffffffc, v);
			apb(1'b0, 12'h00c, 32'h0);
			`CHK("count readback", v & 32'hf001ffff, rd)
			apb(1'b0, 12'h004, 32'h0);
			`CHK("source readback", s, rd)
			wait_idle();
		end
		$display("test registers done");
		apb(1'b1, 12'h000, 32'hffffffff);
		`CHK("status write error", 1'b1, err)
		apb(1'b0, 12'h000, 32'h0);
		`CHK("status after write", 32'h0, rd)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped read", 32'h0, rd)
		`CHK("unmapped error", 1'b1, err)
		$display("test refusals done");
		// Copy and fill, every rank, prompt and slow memory; source and
		// destination sit in different halves, as if on different ports
		for (t = 0; t < 8; t++) begin
			slow <= t[0];
			submit($urandom() | 32'h80000000, $urandom() & 32'h7ffffffc,
				{3'(t), t[1], 11'h0, t[2], 16'(4 * $urandom_range(1, 6))});
			wait_idle();
		end
		$display("test transfers done");
		// Zero-length job queued behind a slow copy
		slow <= 1'b1;
		submit($urandom(), 32'h00800000, 32'h40000020);
		submit(32'h0, 32'h0, 32'ha0000000);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("status queued", 32'h3, rd)
		wait_idle();
		$display("test queue done");
		tally_and_finish();
	end
endmodule
